// ### src/gldm_top.sv
/*
 * global first-level decision core: input latch, eight lookup trigger
 * groups, per-trigger prescale or rate limit, accept to the supervisor,
 * first-level pipeline, four second-level buffers and an apb slave.
 * assumes trigger inputs and the returned final accept are synchronous
 * to mclk and sampled on the crossing tick this module drives out.
 */
`timescale 1ns/1ns
module gldm_top (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [63:0] trig_in,
	input wire logic final_accept,
	output logic cross_tick,
	output logic l1_accept,
	output logic [63:0] l2_trig,
	output logic l2_trig_vld
);

	typedef struct packed {
		logic run;
		logic run_prev;
		logic ovf;
		logic [gldm_pkg::IDX_W-1:0] idx;
		logic [31:0] rdata;
		logic [2:0] div;
		logic tick;
		logic [gldm_pkg::N_IN-1:0] inp;
		logic [gldm_pkg::N_IN-1:0] inp1;
		logic [gldm_pkg::N_IN-1:0][gldm_pkg::PS_W-1:0] pn;
		logic [gldm_pkg::N_IN-1:0] pmode;
		logic [gldm_pkg::N_IN-1:0][gldm_pkg::PS_W-1:0] cnt;
		logic acc;
		logic [gldm_pkg::L1_DEPTH-1:0][gldm_pkg::EVT_W-1:0] pipe;
		logic [gldm_pkg::N_L2-1:0][gldm_pkg::EVT_W-1:0] l2;
		logic [gldm_pkg::N_L2-1:0] full;
		logic [gldm_pkg::N_IN-1:0] l2trig;
		logic l2vld;
		logic [31:0] acc_cnt;
	} gldm_st_t;

	gldm_st_t st_q;
	gldm_st_t st_d;

	gldm_grp_if grp_bus ();

	// ----------------------------------------------------------------
	// lookup trigger groups
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < gldm_pkg::N_GRP; g++) begin : gen_grp
			gldm_lut_group #(
				.GRP(g)
			) u_grp (
				.mclk(mclk),
				.rst_b(rst_b),
				.bus(grp_bus.grp)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic setup_ph;
	logic acc_ph;
	logic hit;
	logic cfg_reg;
	logic bad;
	logic wr_ok;
	logic [gldm_pkg::N_IN-1:0] lut_bits;
	logic [gldm_pkg::N_IN-1:0] pass;
	logic [gldm_pkg::EVT_W-1:0] tail;
	logic [gldm_pkg::EVT_W-1:0] l2_word_src;
	logic [31:0] rd_mux;
	logic [1:0] free_idx;
	logic free_found;
	logic [2:0] lut_grp;
	logic [2:0] sel_grp;
	logic [5:0] ps_idx;
	logic [1:0] l2_buf;
	logic [1:0] l2_word;
	gldm_pkg::gldm_ps_mode_t mode;

	assign setup_ph = psel && !penable;
	assign acc_ph = psel && penable;
	assign lut_grp = st_q.idx[10:8];
	assign sel_grp = st_q.idx[5:3];
	assign ps_idx = st_q.idx[5:0];
	assign l2_buf = st_q.idx[3:2];
	assign l2_word = st_q.idx[1:0];
	assign lut_bits = grp_bus.trig;

	always_comb begin
		hit = 1'b1;
		cfg_reg = 1'b0;
		unique case (paddr)
			gldm_pkg::REG_CTRL,
			gldm_pkg::REG_STATUS,
			gldm_pkg::REG_INDEX,
			gldm_pkg::REG_L2DATA,
			gldm_pkg::REG_L2REL,
			gldm_pkg::REG_ACCCNT: begin
				cfg_reg = 1'b0;
			end
			gldm_pkg::REG_LUT,
			gldm_pkg::REG_SEL,
			gldm_pkg::REG_PRESC: begin
				cfg_reg = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// configuration is frozen while a run is on
	assign bad = !hit || (cfg_reg && pwrite && st_q.run);
	assign wr_ok = acc_ph && pwrite && !bad;
	assign pready = 1'b1;
	assign pslverr = acc_ph && bad;
	assign prdata = st_q.rdata;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	assign l2_word_src = st_q.l2[l2_buf];

	always_comb begin
		rd_mux = '0;
		unique case (paddr)
			gldm_pkg::REG_CTRL: begin
				rd_mux[gldm_pkg::CTRL_RUN] = st_q.run;
			end
			gldm_pkg::REG_STATUS: begin
				rd_mux[gldm_pkg::STAT_RUN] = st_q.run;
				rd_mux[gldm_pkg::STAT_OVF] = st_q.ovf;
				rd_mux[gldm_pkg::STAT_FULL +: gldm_pkg::N_L2] = st_q.full;
			end
			gldm_pkg::REG_INDEX: begin
				rd_mux[gldm_pkg::IDX_W-1:0] = st_q.idx;
			end
			gldm_pkg::REG_LUT: begin
				rd_mux[7:0] = grp_bus.lut_rd[lut_grp];
			end
			gldm_pkg::REG_SEL: begin
				rd_mux[5:0] = grp_bus.sel_rd[sel_grp];
			end
			gldm_pkg::REG_PRESC: begin
				rd_mux[gldm_pkg::PS_W-1:0] = st_q.pn[ps_idx];
				rd_mux[gldm_pkg::PS_MODE] = st_q.pmode[ps_idx];
			end
			gldm_pkg::REG_L2DATA: begin
				rd_mux = l2_word_src[32*l2_word +: 32];
			end
			gldm_pkg::REG_ACCCNT: begin
				rd_mux = st_q.acc_cnt;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// group write port
	// ----------------------------------------------------------------
	always_comb begin
		grp_bus.lut_we = '0;
		grp_bus.sel_we = '0;
		if (wr_ok && paddr == gldm_pkg::REG_LUT) begin
			grp_bus.lut_we[lut_grp] = 1'b1;
		end
		if (wr_ok && paddr == gldm_pkg::REG_SEL) begin
			grp_bus.sel_we[sel_grp] = 1'b1;
		end
	end

	assign grp_bus.addr = st_q.idx[7:0];
	assign grp_bus.slot = st_q.idx[2:0];
	assign grp_bus.wdata = pwdata[7:0];
	assign grp_bus.cross_en = st_q.tick;
	assign grp_bus.in_bits = st_q.inp;

	// ----------------------------------------------------------------
	// second-level buffer choice
	// ----------------------------------------------------------------
	assign tail = st_q.pipe[gldm_pkg::L1_DEPTH-1];

	always_comb begin
		free_idx = '0;
		free_found = 1'b0;
		for (int b = gldm_pkg::N_L2 - 1; b >= 0; b--) begin
			if (!st_q.full[b]) begin
				free_idx = 2'(b);
				free_found = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		pass = '0;
		mode = gldm_pkg::GLDM_PS_DIVIDE;
		st_d.l2vld = 1'b0;
		st_d.run_prev = st_q.run;

		// crossing divider; every stage moves on the tick only
		st_d.tick = (st_q.div == gldm_pkg::CROSS_LAST);
		if (st_q.div == gldm_pkg::CROSS_LAST) begin
			st_d.div = '0;
		end else begin
			st_d.div = st_q.div + 3'h1;
		end

		if (setup_ph) begin
			st_d.rdata = rd_mux;
		end

		// register writes
		if (wr_ok) begin
			unique case (paddr)
				gldm_pkg::REG_CTRL: begin
					st_d.run = pwdata[gldm_pkg::CTRL_RUN];
				end
				gldm_pkg::REG_INDEX: begin
					st_d.idx = pwdata[gldm_pkg::IDX_W-1:0];
				end
				gldm_pkg::REG_LUT,
				gldm_pkg::REG_SEL: begin
					st_d.idx = st_q.idx + gldm_pkg::IDX_ONE;
				end
				gldm_pkg::REG_PRESC: begin
					st_d.pn[ps_idx] = pwdata[gldm_pkg::PS_W-1:0];
					st_d.pmode[ps_idx] = pwdata[gldm_pkg::PS_MODE];
					st_d.idx = st_q.idx + gldm_pkg::IDX_ONE;
				end
				gldm_pkg::REG_L2REL: begin
					st_d.full = st_q.full & ~pwdata[gldm_pkg::N_L2-1:0];
				end
				gldm_pkg::REG_STATUS: begin
					if (pwdata[gldm_pkg::STAT_OVF]) begin
						st_d.ovf = 1'b0;
					end
				end
				default: begin
					st_d.acc_cnt = '0;
				end
			endcase
		end

		// the crossing moves on every tick, also in the first run cycle
		if (st_q.tick) begin
			st_d.inp = trig_in;
			st_d.inp1 = st_q.inp;
			// per trigger: divide-by-N or at most one per N crossings
			for (int t = 0; t < gldm_pkg::N_IN; t++) begin
				mode = st_q.pmode[t] ? gldm_pkg::GLDM_PS_RATE :
					gldm_pkg::GLDM_PS_DIVIDE;
				// n of zero masks the trigger
				unique case (mode)
					gldm_pkg::GLDM_PS_DIVIDE: begin
						if (lut_bits[t] && st_q.pn[t] != gldm_pkg::PS_ZERO) begin
							if (st_q.cnt[t] >= st_q.pn[t] - gldm_pkg::PS_ONE) begin
								pass[t] = 1'b1;
								st_d.cnt[t] = '0;
							end else begin
								st_d.cnt[t] = st_q.cnt[t] + gldm_pkg::PS_ONE;
							end
						end
					end
					gldm_pkg::GLDM_PS_RATE: begin
						if (st_q.cnt[t] != gldm_pkg::PS_ZERO) begin
							st_d.cnt[t] = st_q.cnt[t] - gldm_pkg::PS_ONE;
						end else if (lut_bits[t] &&
							st_q.pn[t] != gldm_pkg::PS_ZERO) begin
							pass[t] = 1'b1;
							st_d.cnt[t] = st_q.pn[t] - gldm_pkg::PS_ONE;
						end
					end
				endcase
			end
			// gating after the lookup register keeps latency fixed
			st_d.acc = st_q.run && (|pass);
			st_d.pipe[0] = {st_q.inp1, lut_bits};
			for (int i = 1; i < gldm_pkg::L1_DEPTH; i++) begin
				st_d.pipe[i] = st_q.pipe[i-1];
			end
			// returned decision refers to the pipeline tail
			if (final_accept && st_q.run) begin
				if (free_found) begin
					st_d.l2[free_idx] = tail;
					st_d.full[free_idx] = 1'b1;
					st_d.l2trig = tail[gldm_pkg::N_IN-1:0];
					st_d.l2vld = 1'b1;
					st_d.acc_cnt = st_q.acc_cnt + gldm_pkg::CNT_ONE;
				end else begin
					// no buffer: event lost; flag set wins over clear
					st_d.ovf = 1'b1;
				end
			end
		end
		// stopped or just started: every divider held at zero
		if (!(st_q.run && st_q.run_prev)) begin
			st_d.cnt = '0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign cross_tick = st_q.tick;
	assign l1_accept = st_q.acc;
	assign l2_trig = st_q.l2trig;
	assign l2_trig_vld = st_q.l2vld;

endmodule

// ### src/gldm_pkg.sv
/*
 * constants, register map and field layout of the global decision module.
 * assumes nothing; the core and group modules refer to it by package::name, the group interface does not.
 */
package gldm_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int MCLK_NS = 20;
	localparam int CROSS_NS = 132;
	// least time: rounded up to whole clock cycles
	localparam int CROSS_CYC = (CROSS_NS + MCLK_NS - 1) / MCLK_NS;
	localparam logic [2:0] CROSS_LAST = 3'(CROSS_CYC - 1);

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int N_IN = 64;
	localparam int N_GRP = 8;
	localparam int GRP_W = 8;
	localparam int LUT_N = 256;
	localparam int SEL_W = 6;
	localparam int PS_W = 16;
	localparam int L1_DEPTH = 8;
	localparam int N_L2 = 4;
	localparam int EVT_W = 2 * N_IN;
	localparam int IDX_W = 11;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_INDEX = 12'h008;
	localparam logic [11:0] REG_LUT = 12'h00c;
	localparam logic [11:0] REG_SEL = 12'h010;
	localparam logic [11:0] REG_PRESC = 12'h014;
	localparam logic [11:0] REG_L2DATA = 12'h018;
	localparam logic [11:0] REG_L2REL = 12'h01c;
	localparam logic [11:0] REG_ACCCNT = 12'h020;

	// ----------------------------------------------------------------
	// fields
	// ----------------------------------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int STAT_RUN = 0;
	localparam int STAT_OVF = 1;
	localparam int STAT_FULL = 4;
	localparam int PS_MODE = 16;
	localparam logic [IDX_W-1:0] IDX_ONE = 11'h001;
	localparam logic [PS_W-1:0] PS_ONE = 16'h0001;
	localparam logic [PS_W-1:0] PS_ZERO = 16'h0000;
	localparam logic [31:0] CNT_ONE = 32'h0000_0001;

	typedef enum logic [1:0] {
		GLDM_PS_DIVIDE = 2'b01,
		GLDM_PS_RATE = 2'b10
	} gldm_ps_mode_t;

endpackage

// ### src/gldm_grp_if.sv
/*
 * carrier between the decision core and its eight lookup trigger groups.
 * assumes one clock; the core drives the control side, each group
 * drives only its own slice of the read and trigger vectors.
 */
`timescale 1ns/1ns
interface gldm_grp_if;
	logic cross_en;
	logic [63:0] in_bits;
	logic [7:0] lut_we;
	logic [7:0] sel_we;
	logic [7:0] addr;
	logic [2:0] slot;
	logic [7:0] wdata;
	// one slice per group, hence nets
	wire [7:0][7:0] lut_rd;
	wire [7:0][5:0] sel_rd;
	wire [7:0][7:0] trig;

	modport ctl (
		output cross_en, in_bits, lut_we, sel_we, addr, slot, wdata,
		input lut_rd, sel_rd, trig
	);
	modport grp (
		input cross_en, in_bits, lut_we, sel_we, addr, slot, wdata,
		output lut_rd, sel_rd, trig
	);
endinterface

// ### src/gldm_lut_group.sv
/*
 * one lookup trigger group: 64-to-eight input crossbar, 256-entry lookup memory
 * of eight trigger bits, and the settle register on its output.
 * assumes the core writes memory and selection only outside a run.
 */
`timescale 1ns/1ns
module gldm_lut_group #(
	parameter int GRP = 0
) (
	input wire logic mclk,
	input wire logic rst_b,
	gldm_grp_if.grp bus
);

	typedef struct packed {
		logic [gldm_pkg::LUT_N-1:0][gldm_pkg::GRP_W-1:0] mem;
		logic [gldm_pkg::GRP_W-1:0][gldm_pkg::SEL_W-1:0] sel;
		logic [gldm_pkg::GRP_W-1:0] trig;
	} gldm_grp_st_t;

	gldm_grp_st_t st_q;
	gldm_grp_st_t st_d;
	logic [gldm_pkg::GRP_W-1:0] lut_addr;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		for (int s = 0; s < gldm_pkg::GRP_W; s++) begin
			lut_addr[s] = bus.in_bits[st_q.sel[s]];
		end
		if (bus.lut_we[GRP]) begin
			st_d.mem[bus.addr] = bus.wdata;
		end
		if (bus.sel_we[GRP]) begin
			st_d.sel[bus.slot] = bus.wdata[gldm_pkg::SEL_W-1:0];
		end
		// memory output settles a full crossing before it is taken
		if (bus.cross_en) begin
			st_d.trig = st_q.mem[lut_addr];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.lut_rd[GRP] = st_q.mem[bus.addr];
	assign bus.sel_rd[GRP] = st_q.sel[bus.slot];
	assign bus.trig[GRP] = st_q.trig;

endmodule

// ### sim/gldm_top_asserts.sv
/*
 * concurrent checks on the ports of the global decision module.
 * assumes one clock mclk and the active-low asynchronous reset rst_b.
 */
`timescale 1ns/1ns
module gldm_top_asserts (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [63:0] trig_in,
	input wire logic final_accept,
	input wire logic cross_tick,
	input wire logic l1_accept,
	input wire logic [63:0] l2_trig,
	input wire logic l2_trig_vld
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// trigger path
	// ----------------------------------------------------------------
	a_tick_period: assert property (cross_tick |=>
		!cross_tick [*6] ##1 cross_tick) else $error("tick spacing wrong");
	a_accept_at_tick: assert property ($changed(l1_accept) |->
		$past(cross_tick)) else $error("accept moved off a tick");
	// two crossings from sampling to decision
	a_accept_cause: assert property ($rose(l1_accept) |->
		$past(trig_in, 15) != 64'h0) else $error("accept without input");
	a_vld_pulse: assert property (l2_trig_vld |=> !l2_trig_vld)
		else $error("second-level strobe too long");
	a_vld_cause: assert property (l2_trig_vld |->
		$past(final_accept) && $past(cross_tick))
		else $error("capture without final accept");
	a_trig_hold: assert property ($changed(l2_trig) |-> l2_trig_vld)
		else $error("second-level bits moved alone");

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("wait state inserted");
	a_unmapped_err: assert property (psel && penable &&
		paddr > 12'h020 |-> pslverr) else $error("unmapped not refused");
endmodule

bind gldm_top gldm_top_asserts i_gldm_top_asserts (.mclk(mclk),
	.rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .trig_in(trig_in), .final_accept(final_accept),
	.cross_tick(cross_tick), .l1_accept(l1_accept), .l2_trig(l2_trig),
	.l2_trig_vld(l2_trig_vld));

// ### sim/gldm_partner.sv
/*
 * upstream summary modules and trigger supervisor unit, behavioural.
 * assumes cross_tick marks the edges where the decision module samples.
 */
`timescale 1ns/1ns
module gldm_partner (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic cross_tick,
	input wire logic l1_accept,
	input wire logic [63:0] pat,
	output logic [63:0] trig_in,
	output logic final_accept
);
	logic [6:0] hist_q;

	// inputs move only at sampling edges, so all 64 belong to one crossing
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			trig_in <= 64'h0;
			hist_q <= 7'h00;
		end else if (cross_tick) begin
			trig_in <= pat;
			hist_q <= {hist_q[5:0], l1_accept};
		end
	end
	// answer lands when the event reaches the pipeline tail, not on the
	// accept line itself
	assign final_accept = hist_q[6];
endmodule

// ### sim/gldm_tb_top.sv
/*
 * self-checking bench for the global decision module.
 * assumes the partner model drives trigger inputs and the final decision.
 */
`timescale 1ns/1ns
module gldm_tb_top;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic e;
	} gldm_row_t;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [63:0] trig_in;
	logic [63:0] pat = 64'h0;
	logic [63:0] exp_trig = 64'h1;
	logic final_accept;
	logic cross_tick;
	logic l1_accept;
	logic [63:0] l2_trig;
	logic l2_trig_vld;
	logic [31:0] rd;
	logic er;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	int acc_n = 0;
	int vld_n = 0;
	int bit_bad = 0;
	gldm_row_t rows [5] = '{
		'{12'h000, 32'h0, 1'b0}, '{12'h004, 32'h0, 1'b0},
		'{12'h008, 32'h0, 1'b0}, '{12'h020, 32'h0, 1'b0},
		'{12'h100, 32'h0, 1'b1}};

	initial begin
		forever #10 mclk = ~mclk;
	end

	gldm_partner i_gldm_partner (.mclk(mclk), .rst_b(rst_b),
		.cross_tick(cross_tick), .l1_accept(l1_accept), .pat(pat),
		.trig_in(trig_in), .final_accept(final_accept));
	gldm_top i_gldm_top (.mclk(mclk), .rst_b(rst_b), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trig_in(trig_in), .final_accept(final_accept),
		.cross_tick(cross_tick), .l1_accept(l1_accept), .l2_trig(l2_trig),
		.l2_trig_vld(l2_trig_vld));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		if (mismatches == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cmp(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one edge before setup keeps back-to-back calls from double driving
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic ticks(input int k);
		repeat (k) @(posedge mclk iff cross_tick === 1'b1);
	endtask

	// ----------------------------------------------------------------
	// monitors and timeout
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		cyc++;
		if (cross_tick === 1'b1 && l1_accept === 1'b1)
			acc_n++;
		if (l2_trig_vld === 1'b1) begin
			vld_n++;
			if (l2_trig !== exp_trig)
				bit_bad++;
		end
		if (cyc == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			cmp("read data", rows[i].d, rd);
			cmp("read error", {31'h0, rows[i].e}, {31'h0, er});
		end
		// trigger 0: group 0 entry 0xff, divide by two
		apb(1'b1, gldm_pkg::REG_INDEX, 32'h0000_00ff);
		apb(1'b1, gldm_pkg::REG_LUT, 32'h0000_0001);
		apb(1'b1, gldm_pkg::REG_INDEX, 32'h0000_0000);
		apb(1'b1, gldm_pkg::REG_PRESC, 32'h0000_0002);
		apb(1'b1, gldm_pkg::REG_CTRL, 32'h0000_0001);
		apb(1'b1, gldm_pkg::REG_LUT, 32'h0000_00ff);
		cmp("running write", 32'h1, {31'h0, er});
		apb(1'b0, gldm_pkg::REG_INDEX, 32'h0);
		cmp("index", 32'h1, rd);
		pat <= 64'h1;
		ticks(12);
		pat <= 64'h0;
		ticks(14);
		cmp("accepts", 32'd6, 32'(acc_n));
		cmp("captures", 32'd4, 32'(vld_n));
		cmp("bad bits", 32'd0, 32'(bit_bad));
		apb(1'b0, gldm_pkg::REG_STATUS, 32'h0);
		cmp("status", 32'h0000_00f3, rd);
		apb(1'b0, gldm_pkg::REG_ACCCNT, 32'h0);
		cmp("capture count", 32'd4, rd);
		apb(1'b1, gldm_pkg::REG_L2REL, 32'h0000_000f);
		apb(1'b1, gldm_pkg::REG_STATUS, 32'h0000_0002);
		apb(1'b0, gldm_pkg::REG_STATUS, 32'h0);
		cmp("released", 32'h0000_0001, rd);
		// stopped run rejects everything
		apb(1'b1, gldm_pkg::REG_CTRL, 32'h0000_0000);
		pat <= 64'h1;
		ticks(6);
		pat <= 64'h0;
		ticks(3);
		cmp("stopped accepts", 32'd6, 32'(acc_n));
		// group 1 slot 0 reads input 5; entry 0x01 gives trigger 10,
		// rate limited: one pass, then two crossings blocked
		apb(1'b1, gldm_pkg::REG_INDEX, 32'h0000_0008);
		apb(1'b1, gldm_pkg::REG_SEL, 32'h0000_0005);
		apb(1'b1, gldm_pkg::REG_INDEX, 32'h0000_0101);
		apb(1'b1, gldm_pkg::REG_LUT, 32'h0000_0004);
		apb(1'b1, gldm_pkg::REG_INDEX, 32'h0000_000a);
		apb(1'b1, gldm_pkg::REG_PRESC, 32'h0001_0003);
		apb(1'b1, gldm_pkg::REG_INDEX, 32'h0000_000a);
		apb(1'b0, gldm_pkg::REG_PRESC, 32'h0);
		cmp("presc readback", 32'h0001_0003, rd);
		apb(1'b1, gldm_pkg::REG_CTRL, 32'h0000_0001);
		exp_trig <= 64'h0000_0000_0000_0400;
		pat <= 64'h20;
		ticks(9);
		pat <= 64'h0;
		ticks(14);
		cmp("rate accepts", 32'd9, 32'(acc_n));
		cmp("rate captures", 32'd7, 32'(vld_n));
		cmp("rate bad bits", 32'd0, 32'(bit_bad));
		apb(1'b1, gldm_pkg::REG_INDEX, 32'h0000_0000);
		apb(1'b0, gldm_pkg::REG_L2DATA, 32'h0);
		cmp("buffer trig", 32'h0000_0400, rd);
		apb(1'b1, gldm_pkg::REG_INDEX, 32'h0000_0002);
		apb(1'b0, gldm_pkg::REG_L2DATA, 32'h0);
		cmp("buffer inputs", 32'h0000_0020, rd);
		// reset in mid-run drops the run, the buffers and the outputs
		rst_b <= 1'b0;
		@(posedge mclk);
		cmp("reset accept", 32'h0, {31'h0, l1_accept});
		cmp("reset l2 bits", 32'h0, l2_trig[31:0]);
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		apb(1'b0, gldm_pkg::REG_STATUS, 32'h0);
		cmp("reset status", 32'h0, rd);
		complete_run();
	end
endmodule
